// ===== include/dpc_pkg.sv
// Constants for the datapath pattern checker: sizes, register indices,
// field positions and reset values.
// Assumes an APB master with 32-bit data; each register takes one aligned word.

package dpc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int CHAN_N = 6;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int HIST_W = 7;
  localparam int TAP_A = 7;
  localparam int TAP_B = 6;
  localparam int SUM_W = 11;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam logic POLY_PRBS7 = 1'b0;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h14b;
  localparam logic [IDX_W-1:0] IDX_ERR_I = 10'h14c;
  localparam logic [IDX_W-1:0] IDX_ERR_Q = 10'h14d;
  localparam logic [IDX_W-1:0] IDX_CHSEL = 10'h14e;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h160;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 10'h161;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h162;

  // ---------------------------------------------------------------
  // Control/status register fields
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_POLY_BIT = 2;
  localparam int CTRL_INV_I_BIT = 3;
  localparam int CTRL_INV_Q_BIT = 4;
  localparam int CTRL_PASS_I_BIT = 6;
  localparam int CTRL_PASS_Q_BIT = 7;
  localparam logic CTRL_BIT_RST = 1'b0;

  localparam int CHSEL_W = 3;
  localparam logic [CHSEL_W-1:0] CHSEL_RST = 3'h7;
  localparam logic [CHSEL_W-1:0] CHSEL_AGG = 3'h6;

  localparam int IRQ_W = 3;
  localparam int IRQ_ERR_I_BIT = 0;
  localparam int IRQ_ERR_Q_BIT = 1;
  localparam int IRQ_SAT_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

endpackage : dpc_pkg

// ===== verif/dpc_checker.sv
// Port-level assertions for the pattern checker top.
// Assumes an APB master that holds its request through the access cycle.
`timescale 1ns/100ps
`default_nettype none

module dpc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  import dpc_pkg::*;
  // ---------------------------------------------
  // Shadow of selector and interrupt mask
  // ---------------------------------------------
  logic [2:0] sel_ff, en_ff;
  logic [IDX_W-1:0] idx;
  logic cnt_rd;
  assign idx = paddr[11:2];
  assign cnt_rd = pready && !pwrite && (idx == IDX_ERR_I || idx == IDX_ERR_Q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= CHSEL_RST;
      en_ff <= IRQ_RST;
    end else if (psel && penable && pready && pwrite) begin
      if (idx == IDX_CHSEL) sel_ff <= pwdata[2:0];
      if (idx == IDX_IRQ_EN) en_ff <= pwdata[2:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("pready without setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
  unmapped_err_a: assert property (psel && !penable && idx > IDX_IRQ_EN |=> pslverr)
    else $error("unmapped access not refused");
  ro_count_a: assert property (psel && !penable && pwrite && (idx == IDX_ERR_I || idx == IDX_ERR_Q)
    |=> pslverr ##1 !pslverr) else $error("count write not refused");
  count_width_a: assert property (cnt_rd |-> prdata[31:8] == 24'h0) else $error("count wider than 8 bits");
  sel_idle_a: assert property (cnt_rd && sel_ff == 3'h7 |-> prdata == 32'h0)
    else $error("code 7 count not zero");
  chsel_read_a: assert property (pready && !pwrite && idx == IDX_CHSEL |-> prdata == {29'h0, sel_ff})
    else $error("selector readback wrong");
  irq_masked_a: assert property (en_ff == 3'h0 && $past(en_ff) == 3'h0 |-> !irq)
    else $error("irq while masked");

  cover property (irq);
  cover property (pslverr);
  cover property (cnt_rd && prdata != 32'h0);
endmodule : dpc_checker

bind dpc_top dpc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

`default_nettype wire

// ===== verif/dpc_src.sv
// Pattern source model: sends x^7 + x^6 + 1 words on all six channels.
// Assumes the bench pulses err_i/err_q to corrupt the next valid word.
`timescale 1ns/100ps
`default_nettype none

module dpc_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic invert_q,
  input wire logic [5:0] err_i,
  input wire logic [5:0] err_q,
  output logic [5:0] channel_valid,
  output logic [5:0][15:0] i_data,
  output logic [5:0][15:0] q_data
);
  // ---------------------------------------------
  // Generator
  // ---------------------------------------------
  logic [6:0] st_ff, ns;
  logic [1:0] ph_ff;
  logic [5:0] pi_ff, pq_ff;
  logic [15:0] w, wq;
  logic valid;

  always_comb begin
    ns = st_ff;
    for (int k = 15; k >= 0; k--) begin
      w[k] = ns[6] ^ ns[5];
      ns = {ns[5:0], w[k]};
    end
    wq = w ^ {16{invert_q}};
  end

  // Every fourth cycle idles so the checker sees gaps
  assign valid = run && (ph_ff != 2'h3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= 7'h7f;
      ph_ff <= 2'h0;
      pi_ff <= 6'h0;
      pq_ff <= 6'h0;
    end else begin
      ph_ff <= ph_ff + 2'h1;
      pi_ff <= valid ? err_i : (pi_ff | err_i);
      pq_ff <= valid ? err_q : (pq_ff | err_q);
      if (valid) begin
        st_ff <= ns;
      end
    end
  end

  // Idle words show the inverse so stale data never looks valid
  always_comb begin
    for (int c = 0; c < 6; c++) begin
      channel_valid[c] = valid;
      i_data[c] = valid ? (w ^ {pi_ff[c], 15'h0}) : ~w;
      q_data[c] = valid ? (wq ^ {pq_ff[c], 15'h0}) : ~wq;
    end
  end
endmodule : dpc_src

`default_nettype wire

// ===== verif/tb_top.sv
// Bench for the pattern checker: APB register tests with a pattern source.
// Assumes the source model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import dpc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv, ei, eq, ec;
  logic pready, pslverr, irq, erv;
  logic [CHAN_N-1:0] err_i = '0, err_q = '0, channel_valid;
  logic [CHAN_N-1:0][DATA_W-1:0] i_sample_data, q_sample_data;
  int errors = 0, tests_run = 0;

  always #5 pclk = ~pclk;

  dpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_valid(channel_valid), .i_sample_data(i_sample_data), .q_sample_data(q_sample_data), .irq(irq));
  // Q words are sent inverted; the lanes must be told to expect that
  dpc_src i_src (.pclk(pclk), .presetn(presetn), .run(run), .invert_q(1'b1), .err_i(err_i), .err_q(err_q),
    .channel_valid(channel_valid), .i_data(i_sample_data), .q_data(q_sample_data));

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      end_sim;
    end else begin
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    chk({31'h0, erv}, 32'h0);
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
    chk({31'h0, erv}, 32'h0);
  endtask : rd

  // Corrupts bit 15 of the next valid word, then lets the lanes settle
  task automatic inject(input logic [5:0] mi, input logic [5:0] mq);
    err_i <= mi;
    err_q <= mq;
    @(posedge pclk);
    err_i <= 6'h0;
    err_q <= 6'h0;
    repeat (8) @(posedge pclk);
  endtask : inject

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CTRL, 32'h0);
    rd(IDX_CHSEL, 32'h7);
    rd(IDX_ERR_I, 32'h0);
    rd(IDX_ERR_Q, 32'h0);
    rd(IDX_IRQ_EN, 32'h0);
    apb(1'b0, 10'h200, 32'h0);
    chk({rdv[30:0], erv}, 32'h1);
    apb(1'b1, IDX_ERR_I, 32'h55);
    chk({31'h0, erv}, 32'h1);
    wr(IDX_IRQ_EN, 32'h3);
    run <= 1'b1;
    wr(IDX_CTRL, 32'h13);
    wr(IDX_CTRL, 32'h11);
    wr(IDX_CHSEL, 32'h0);
    rd(IDX_CTRL, 32'hd1);
    chk({31'h0, irq}, 32'h0);
    inject(6'h02, 6'h00);
    inject(6'h00, 6'h10);
    inject(6'h00, 6'h10);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_IRQ_STAT, 32'h3);
    for (int s = 0; s < 8; s++) begin
      ei = (s == 1 || s == 6) ? 32'h1 : 32'h0;
      eq = (s == 4 || s == 6) ? 32'h2 : 32'h0;
      ec = 32'h11;
      ec[6] = (s < 7) && (s != 1);
      ec[7] = (s < 7) && (s != 4);
      wr(IDX_CHSEL, 32'(s));
      rd(IDX_ERR_I, ei);
      rd(IDX_ERR_Q, eq);
      rd(IDX_CTRL, ec);
    end
    wr(IDX_CHSEL, 32'h6);
    wr(IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_CLR, 32'h3);
    rd(IDX_IRQ_STAT, 32'h0);
    rd(IDX_IRQ_CLR, 32'h0);
    wr(IDX_IRQ_EN, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_CTRL, 32'h13);
    rd(IDX_ERR_I, 32'h0);
    rd(IDX_ERR_Q, 32'h0);
    rd(IDX_CTRL, 32'hd3);
    wr(IDX_CTRL, 32'h10);
    inject(6'h01, 6'h00);
    rd(IDX_ERR_I, 32'h0);
    wr(IDX_CTRL, 32'h15);
    inject(6'h01, 6'h00);
    rd(IDX_ERR_I, 32'h0);
    wr(IDX_CTRL, 32'h11);
    repeat (4) @(posedge pclk);
    inject(6'h01, 6'h00);
    rd(IDX_ERR_I, 32'h1);
    wr(IDX_CTRL, 32'h01);
    repeat (8) @(posedge pclk);
    rd(IDX_CTRL, 32'h41);
    // Inverted Q words keep failing, so every Q tally runs into saturation
    repeat (400) @(posedge pclk);
    rd(IDX_ERR_Q, 32'hff);
    rd(IDX_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_IRQ_STAT, 32'h0);
    chk({31'h0, erv}, 32'h1);
    // I lanes told to expect inversion while the source sends normal I words
    wr(IDX_CTRL, 32'h1b);
    wr(IDX_CTRL, 32'h19);
    repeat (8) @(posedge pclk);
    rd(IDX_CTRL, 32'h99);
    // Reset in mid-run brings every register back to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_CHSEL, 32'h7);
    rd(IDX_CTRL, 32'h0);
    rd(IDX_ERR_Q, 32'h0);
    end_sim;
  end
endmodule : tb_top

`default_nettype wire

// ===== verilog/dpc_lane_checker.sv
// One pattern checker lane: self-synchronising x^7 + x^6 + 1 check on
// 16-bit samples, sticky pass flag and saturating error tally.
// Assumes samples arrive on pclk from logic in the same domain, MSB first.
`timescale 1ns/100ps
`default_nettype none

module dpc_lane_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pattern_check_enable,
  input wire logic pattern_err_clear,
  input wire logic expect_inverted,
  input wire logic polynomial_select,
  input wire logic sample_valid,
  input wire logic [dpc_pkg::DATA_W-1:0] sample_data,
  output logic pass_flag,
  output logic [dpc_pkg::CNT_W-1:0] error_tally,
  output logic error_pulse
);
  import dpc_pkg::*;

  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic primed;
    logic pass;
    logic [CNT_W-1:0] tally;
    logic err;
  } dpc_lane_t;

  dpc_lane_t cur_ff;
  dpc_lane_t nxt_lane;
  logic [DATA_W-1:0] aligned;

  // Every received bit must equal the bits 7 and 6 places older xor-ed
  function automatic logic word_mismatch(input logic [HIST_W-1:0] hist, input logic [DATA_W-1:0] w);
    logic [HIST_W+DATA_W-1:0] v;
    logic bad;
    v = {hist, w};
    bad = 1'b0;
    for (int p = 0; p < DATA_W; p++) begin
      bad = bad | (v[p] ^ v[p+TAP_A] ^ v[p+TAP_B]);
    end
    return bad;
  endfunction : word_mismatch

  always_comb begin
    nxt_lane = cur_ff;
    nxt_lane.err = 1'b0;
    aligned = sample_data ^ {DATA_W{expect_inverted}};
    // History is built from received bits, so the lane locks after one word
    if (!pattern_check_enable || polynomial_select != POLY_PRBS7) begin
      nxt_lane.primed = 1'b0;
    end else if (sample_valid) begin
      nxt_lane.hist = aligned[HIST_W-1:0];
      nxt_lane.primed = 1'b1;
      if (cur_ff.primed && word_mismatch(cur_ff.hist, aligned)) begin
        nxt_lane.err = 1'b1;
        nxt_lane.pass = 1'b0;
        if (cur_ff.tally != CNT_MAX) begin
          nxt_lane.tally = cur_ff.tally + 8'h01;
        end
      end
    end
    // Clear is a held level; while it stands counting is frozen at zero
    if (pattern_err_clear) begin
      nxt_lane.pass = 1'b1;
      nxt_lane.tally = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_lane;
    end
  end

  assign pass_flag = cur_ff.pass;
  assign error_tally = cur_ff.tally;
  assign error_pulse = cur_ff.err;

endmodule : dpc_lane_checker

`default_nettype wire

// ===== verilog/dpc_top.sv
// Datapath pattern checker top: twelve checker lanes (I and Q path of six
// channels), APB register slave, channel readback mux and interrupt.
// Assumes APB master on pclk; sample sources are logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module dpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dpc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dpc_pkg::CHAN_N-1:0] channel_valid,
  input wire logic [dpc_pkg::CHAN_N-1:0][dpc_pkg::DATA_W-1:0] i_sample_data,
  input wire logic [dpc_pkg::CHAN_N-1:0][dpc_pkg::DATA_W-1:0] q_sample_data,
  output logic irq
);
  import dpc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic clr;
    logic poly;
    logic inv_i;
    logic inv_q;
    logic [CHSEL_W-1:0] chsel;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dpc_regs_t;

  dpc_regs_t regs_ff;
  dpc_regs_t nxt_regs;

  logic [CHAN_N-1:0] i_pass;
  logic [CHAN_N-1:0] q_pass;
  logic [CHAN_N-1:0] i_err;
  logic [CHAN_N-1:0] q_err;
  logic [CHAN_N-1:0][CNT_W-1:0] i_tally;
  logic [CHAN_N-1:0][CNT_W-1:0] q_tally;

  // ---------------------------------------------------------------
  // Checker lanes
  // ---------------------------------------------------------------
  // Channels 0..2 belong to the first converter, 3..5 to the second
  for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
    dpc_lane_checker u_i_lane (
      .pclk(pclk),
      .presetn(presetn),
      .pattern_check_enable(regs_ff.en),
      .pattern_err_clear(regs_ff.clr),
      .expect_inverted(regs_ff.inv_i),
      .polynomial_select(regs_ff.poly),
      .sample_valid(channel_valid[ch]),
      .sample_data(i_sample_data[ch]),
      .pass_flag(i_pass[ch]),
      .error_tally(i_tally[ch]),
      .error_pulse(i_err[ch])
    );
    dpc_lane_checker u_q_lane (
      .pclk(pclk),
      .presetn(presetn),
      .pattern_check_enable(regs_ff.en),
      .pattern_err_clear(regs_ff.clr),
      .expect_inverted(regs_ff.inv_q),
      .polynomial_select(regs_ff.poly),
      .sample_valid(channel_valid[ch]),
      .sample_data(q_sample_data[ch]),
      .pass_flag(q_pass[ch]),
      .error_tally(q_tally[ch]),
      .error_pulse(q_err[ch])
    );
  end

  // ---------------------------------------------------------------
  // Readback selection
  // ---------------------------------------------------------------
  // Codes 6 aggregates, code 7 (the reset value) reads as zero
  function automatic logic pick_flag(input logic [CHSEL_W-1:0] sel, input logic [CHAN_N-1:0] f);
    logic r;
    r = 1'b0;
    if (sel < CHSEL_W'(CHAN_N)) begin
      r = f[sel];
    end else if (sel == CHSEL_AGG) begin
      r = |f;
    end
    return r;
  endfunction : pick_flag

  // The aggregate sum saturates so a large total never wraps to a small one
  function automatic logic [CNT_W-1:0] pick_count(input logic [CHSEL_W-1:0] sel,
                                                  input logic [CHAN_N-1:0][CNT_W-1:0] c);
    logic [CNT_W-1:0] r;
    logic [SUM_W-1:0] sum;
    r = '0;
    sum = '0;
    for (int k = 0; k < CHAN_N; k++) begin
      sum = sum + SUM_W'(c[k]);
    end
    if (sel < CHSEL_W'(CHAN_N)) begin
      r = c[sel];
    end else if (sel == CHSEL_AGG) begin
      r = (sum > SUM_W'(CNT_MAX)) ? CNT_MAX : sum[CNT_W-1:0];
    end
    return r;
  endfunction : pick_count

  logic sel_pass_i;
  logic sel_pass_q;
  logic [CNT_W-1:0] sel_count_i;
  logic [CNT_W-1:0] sel_count_q;

  assign sel_pass_i = pick_flag(regs_ff.chsel, i_pass);
  assign sel_pass_q = pick_flag(regs_ff.chsel, q_pass);
  assign sel_count_i = pick_count(regs_ff.chsel, i_tally);
  assign sel_count_q = pick_count(regs_ff.chsel, q_tally);

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] events;
  logic sat_hit;

  always_comb begin
    sat_hit = 1'b0;
    for (int k = 0; k < CHAN_N; k++) begin
      sat_hit = sat_hit | (i_err[k] && i_tally[k] == CNT_MAX) | (q_err[k] && q_tally[k] == CNT_MAX);
    end
    events = '0;
    events[IRQ_ERR_I_BIT] = |i_err;
    events[IRQ_ERR_Q_BIT] = |q_err;
    events[IRQ_SAT_BIT] = sat_hit;
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic read_only;
  logic [31:0] rdata;

  assign idx = paddr[ADDR_W-1:2];
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && regs_ff.pready;

  always_comb begin
    mapped = 1'b1;
    read_only = 1'b0;
    rdata = '0;
    unique case (idx)
      IDX_CTRL: begin
        rdata[CTRL_EN_BIT] = regs_ff.en;
        rdata[CTRL_CLR_BIT] = regs_ff.clr;
        rdata[CTRL_POLY_BIT] = regs_ff.poly;
        rdata[CTRL_INV_I_BIT] = regs_ff.inv_i;
        rdata[CTRL_INV_Q_BIT] = regs_ff.inv_q;
        rdata[CTRL_PASS_I_BIT] = sel_pass_i;
        rdata[CTRL_PASS_Q_BIT] = sel_pass_q;
      end
      IDX_ERR_I: begin
        rdata[CNT_W-1:0] = sel_count_i;
        read_only = 1'b1;
      end
      IDX_ERR_Q: begin
        rdata[CNT_W-1:0] = sel_count_q;
        read_only = 1'b1;
      end
      IDX_CHSEL: begin
        rdata[CHSEL_W-1:0] = regs_ff.chsel;
      end
      IDX_IRQ_STAT: begin
        rdata[IRQ_W-1:0] = regs_ff.irq_stat;
        read_only = 1'b1;
      end
      IDX_IRQ_CLR: begin
        rdata = '0;
      end
      IDX_IRQ_EN: begin
        rdata[IRQ_W-1:0] = regs_ff.irq_en;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic do_write;
  logic [IRQ_W-1:0] clr_mask;

  always_comb begin
    nxt_regs = regs_ff;
    do_write = access_ph && pwrite && !regs_ff.pslverr;
    clr_mask = '0;

    // Answer is prepared in the setup cycle so every APB output is a flop;
    // the access phase therefore always lasts exactly one cycle
    nxt_regs.pready = setup_ph;
    nxt_regs.pslverr = setup_ph && (!mapped || (pwrite && read_only));
    nxt_regs.prdata = (setup_ph && !pwrite && mapped) ? rdata : '0;

    if (do_write) begin
      unique case (idx)
        IDX_CTRL: begin
          nxt_regs.en = pwdata[CTRL_EN_BIT];
          nxt_regs.clr = pwdata[CTRL_CLR_BIT];
          nxt_regs.poly = pwdata[CTRL_POLY_BIT];
          nxt_regs.inv_i = pwdata[CTRL_INV_I_BIT];
          nxt_regs.inv_q = pwdata[CTRL_INV_Q_BIT];
        end
        IDX_CHSEL: begin
          nxt_regs.chsel = pwdata[CHSEL_W-1:0];
        end
        IDX_IRQ_CLR: begin
          clr_mask = pwdata[IRQ_W-1:0];
        end
        IDX_IRQ_EN: begin
          nxt_regs.irq_en = pwdata[IRQ_W-1:0];
        end
        default: begin
          nxt_regs.en = regs_ff.en;
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear
    nxt_regs.irq_stat = (regs_ff.irq_stat & ~clr_mask) | events;
    nxt_regs.irq = |(nxt_regs.irq_stat & nxt_regs.irq_en);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_ff.en <= CTRL_BIT_RST;
      regs_ff.clr <= CTRL_BIT_RST;
      regs_ff.poly <= CTRL_BIT_RST;
      regs_ff.inv_i <= CTRL_BIT_RST;
      regs_ff.inv_q <= CTRL_BIT_RST;
      regs_ff.chsel <= CHSEL_RST;
      regs_ff.irq_stat <= IRQ_RST;
      regs_ff.irq_en <= IRQ_RST;
      regs_ff.irq <= 1'b0;
      regs_ff.prdata <= '0;
      regs_ff.pready <= 1'b0;
      regs_ff.pslverr <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = regs_ff.prdata;
  assign pready = regs_ff.pready;
  assign pslverr = regs_ff.pslverr;
  assign irq = regs_ff.irq;

endmodule : dpc_top

`default_nettype wire
